// file: inc/cpu_regfile_pkg.sv
// shared constants, types and helpers for the cpu register file block
package cpu_regfile_pkg;

  // ----------------------------------------
  // register file shape
  // ----------------------------------------
  localparam int REG_COUNT = 32;
  localparam int DATA_W = 8;
  localparam int IDX_W = 5;
  localparam logic [4:0] PTR_X_LO_IDX = 5'h1a;
  localparam logic [4:0] PTR_Y_LO_IDX = 5'h1c;
  localparam logic [4:0] PTR_Z_LO_IDX = 5'h1e;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------
  // data space map
  // ----------------------------------------
  localparam logic [15:0] REG_BASE = 16'h0000;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] IO_LAST = 16'h005f;
  localparam logic [15:0] SRAM_BASE = 16'h0060;
  localparam int SRAM_BYTES = 512;
  localparam logic [5:0] SP_LO_IO = 6'h3e;
  localparam logic [5:0] SP_HI_IO = 6'h3f;
  localparam logic [15:0] SP_RESET = 16'h0000;

  // ----------------------------------------
  // program side
  // ----------------------------------------
  localparam int PC_W = 12;
  localparam int INSTR_W = 16;
  localparam logic [11:0] PC_RESET = 12'h000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_DIRECT = 3'b000,
    MODE_INDIRECT = 3'b001,
    MODE_PREDEC = 3'b010,
    MODE_POSTINC = 3'b011,
    MODE_DISP = 3'b100,
    MODE_IO = 3'b101
  } ds_mode_type;

  typedef enum logic [1:0] {
    PTR_X = 2'b00,
    PTR_Y = 2'b01,
    PTR_Z = 2'b10
  } ptr_sel_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_IO_WAIT = 3'b001,
    ST_MEM_WAIT = 3'b010,
    ST_PUSH_HI = 3'b011,
    ST_POP_A = 3'b100,
    ST_POP_B = 3'b101
  } ds_state_type;

  // register index as seen by an immediate-form instruction: upper half only
  function automatic logic [4:0] eff_idx(input logic [4:0] idx, input logic imm);
    eff_idx = imm ? {1'b1, idx[3:0]} : idx;
  endfunction

endpackage

// file: src/data_sram.sv
// byte-wide internal data memory with registered read data
`timescale 1ns/10ps
module data_sram #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  input wire logic clock,
  input wire logic re,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [DEPTH];

  if (DEPTH < 2 || (1 << AW) < DEPTH) begin : g_chk
    $error("data_sram: address width too small for depth");
  end

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // write and registered read; no reset on the array itself
  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule

// file: src/ptr_addr_unit.sv
// effective data-space address and pointer update for each addressing mode
`timescale 1ns/10ps
module ptr_addr_unit (
  input cpu_regfile_pkg::ds_mode_type mode,
  input cpu_regfile_pkg::ptr_sel_type sel,
  input wire logic [5:0] disp,
  input wire logic [15:0] direct_addr,
  input wire logic [15:0] ptr_x,
  input wire logic [15:0] ptr_y,
  input wire logic [15:0] ptr_z,
  output logic [15:0] ea,
  output logic ptr_we,
  output logic [15:0] ptr_new
);
  import cpu_regfile_pkg::*;

  logic [15:0] base;

  // ----------------------------------------
  // address arithmetic
  // ----------------------------------------
  // pick the pointer, then form the address and any write-back value
  always_comb begin
    unique case (sel)
      PTR_Y: base = ptr_y;
      PTR_Z: base = ptr_z;
      default: base = ptr_x; // code 2'b11 reads as x
    endcase
    ea = base;
    ptr_we = 1'b0;
    ptr_new = base;
    unique case (mode)
      MODE_DIRECT: ea = direct_addr;
      MODE_IO: ea = IO_BASE + {10'h000, disp};
      MODE_INDIRECT: ea = base;
      MODE_PREDEC: begin
        ptr_new = base - 16'h0001;
        ea = ptr_new;
        ptr_we = 1'b1;
      end
      MODE_POSTINC: begin
        ptr_new = base + 16'h0001;
        ptr_we = 1'b1;
      end
      MODE_DISP: begin
        // displacement applies to y, z and code 2'b11 (based on x), not to x
        if (sel != PTR_X) begin
          ea = base + {10'h000, disp};
        end
      end
      default: ea = base;
    endcase
  end

endmodule

// file: src/cpu_regfile.sv
// cpu general-purpose register file with data-space map, stack and fetch stage
`timescale 1ns/10ps
module cpu_regfile #(
  parameter int SRAM_DEPTH = cpu_regfile_pkg::SRAM_BYTES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [cpu_regfile_pkg::IDX_W-1:0] rs_a_idx,
  input wire logic [cpu_regfile_pkg::IDX_W-1:0] rs_b_idx,
  input wire logic rs_imm,
  output logic [cpu_regfile_pkg::DATA_W-1:0] operand_a,
  output logic [cpu_regfile_pkg::DATA_W-1:0] operand_b,
  input wire logic res_we,
  input wire logic [cpu_regfile_pkg::IDX_W-1:0] res_idx,
  input wire logic res_imm,
  input wire logic [cpu_regfile_pkg::DATA_W-1:0] res_data,
  output logic [15:0] ptr_x,
  output logic [15:0] ptr_y,
  output logic [15:0] ptr_z,
  input wire logic ds_req,
  input wire logic ds_we,
  input cpu_regfile_pkg::ds_mode_type ds_mode,
  input cpu_regfile_pkg::ptr_sel_type ds_ptr_sel,
  input wire logic [5:0] ds_disp,
  input wire logic [15:0] ds_addr,
  input wire logic [7:0] ds_wdata,
  output logic [7:0] ds_rdata,
  output logic ds_done,
  output logic ds_busy,
  output logic io_req,
  output logic io_we,
  output logic [5:0] io_idx,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic [cpu_regfile_pkg::PC_W-1:0] stk_pc_in,
  output logic [cpu_regfile_pkg::PC_W-1:0] stk_pc_out,
  output logic [15:0] stack_pointer,
  output logic [cpu_regfile_pkg::PC_W-1:0] pm_addr,
  input wire logic [cpu_regfile_pkg::INSTR_W-1:0] pm_data,
  output logic [cpu_regfile_pkg::INSTR_W-1:0] instr,
  output logic instr_valid,
  input wire logic rel_jump,
  input wire logic [cpu_regfile_pkg::PC_W-1:0] rel_offset
);
  import cpu_regfile_pkg::*;

  localparam int AW = $clog2(SRAM_DEPTH);

  if (SRAM_DEPTH < 2 || SRAM_DEPTH > 65536 - 96) begin : g_chk
    $error("cpu_regfile: sram depth does not fit the data space");
  end

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [7:0] regs_r [REG_COUNT];
  logic [7:0] regs_nxt [REG_COUNT];
  logic [7:0] operand_a_r, operand_a_nxt, operand_b_r, operand_b_nxt;
  ds_state_type state_r, state_nxt;
  logic [15:0] sp_r, sp_nxt;
  logic [7:0] ds_rdata_r, ds_rdata_nxt;
  logic ds_done_r, ds_done_nxt, ds_busy_r, ds_busy_nxt;
  logic io_req_r, io_req_nxt, io_we_r, io_we_nxt;
  logic [5:0] io_idx_r, io_idx_nxt;
  logic [7:0] io_wdata_r, io_wdata_nxt;
  logic [PC_W-1:0] pc_hold_r, pc_hold_nxt, stk_pc_r, stk_pc_nxt;
  logic [PC_W-1:0] pm_addr_r, pm_addr_nxt, instr_pc_r, instr_pc_nxt;
  logic [INSTR_W-1:0] instr_r, instr_nxt;
  logic instr_valid_r, instr_valid_nxt;
  logic mem_re, mem_we;
  logic [AW-1:0] mem_addr;
  logic [7:0] mem_wdata, mem_q;
  logic [15:0] ea, ptr_new;
  logic ptr_we;
  logic [5:0] io_off;
  logic [4:0] ptr_lo;

  // true when a data-space address lands in the internal sram
  function automatic logic in_sram(input logic [15:0] a);
    in_sram = (a >= SRAM_BASE) && ({16'h0000, a} < {16'h0000, SRAM_BASE} + 32'(SRAM_DEPTH));
  endfunction

  // sram word index for a data-space address
  function automatic logic [AW-1:0] sram_idx(input logic [15:0] a);
    logic [15:0] d;
    d = a - SRAM_BASE;
    sram_idx = d[AW-1:0];
  endfunction

  // ----------------------------------------
  // pointer outputs and address unit
  // ----------------------------------------
  // pointers come straight from the register storage, low byte first
  assign ptr_x = {regs_r[PTR_X_LO_IDX + 5'd1], regs_r[PTR_X_LO_IDX]};
  assign ptr_y = {regs_r[PTR_Y_LO_IDX + 5'd1], regs_r[PTR_Y_LO_IDX]};
  assign ptr_z = {regs_r[PTR_Z_LO_IDX + 5'd1], regs_r[PTR_Z_LO_IDX]};

  ptr_addr_unit u_ptr (
    .mode(ds_mode),
    .sel(ds_ptr_sel),
    .disp(ds_disp),
    .direct_addr(ds_addr),
    .ptr_x(ptr_x),
    .ptr_y(ptr_y),
    .ptr_z(ptr_z),
    .ea(ea),
    .ptr_we(ptr_we),
    .ptr_new(ptr_new)
  );

  data_sram #(.DEPTH(SRAM_DEPTH), .AW(AW)) u_sram (
    .clock(clock),
    .re(mem_re),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_q)
  );

  assign io_off = 6'(ea - IO_BASE);

  always_comb begin
    unique case (ds_ptr_sel)
      PTR_Y: ptr_lo = PTR_Y_LO_IDX;
      PTR_Z: ptr_lo = PTR_Z_LO_IDX;
      default: ptr_lo = PTR_X_LO_IDX;
    endcase
  end

  // ----------------------------------------
  // register file, data space and stack
  // ----------------------------------------
  // one next-state pass: pointer update, data-space access, then result write
  always_comb begin
    regs_nxt = regs_r;
    state_nxt = state_r;
    sp_nxt = sp_r;
    ds_rdata_nxt = ds_rdata_r;
    ds_done_nxt = 1'b0;
    io_req_nxt = 1'b0;
    io_we_nxt = io_we_r;
    io_idx_nxt = io_idx_r;
    io_wdata_nxt = io_wdata_r;
    pc_hold_nxt = pc_hold_r;
    stk_pc_nxt = stk_pc_r;
    mem_re = 1'b0;
    mem_we = 1'b0;
    mem_addr = '0;
    mem_wdata = 8'h00;
    unique case (state_r)
      ST_IDLE: begin
        if (stk_push) begin
          // return address low byte at sp, then high byte below it
          pc_hold_nxt = stk_pc_in;
          mem_we = in_sram(sp_r);
          mem_addr = sram_idx(sp_r);
          mem_wdata = stk_pc_in[7:0];
          sp_nxt = sp_r - 16'h0001;
          state_nxt = ST_PUSH_HI;
        end else if (stk_pop) begin
          mem_re = 1'b1;
          mem_addr = sram_idx(sp_r + 16'h0001);
          sp_nxt = sp_r + 16'h0001;
          state_nxt = ST_POP_A;
        end else if (ds_req) begin
          if (ptr_we) begin
            regs_nxt[ptr_lo] = ptr_new[7:0];
            regs_nxt[ptr_lo + 5'd1] = ptr_new[15:8];
          end
          if (ea < IO_BASE) begin
            // register range, also reached through any pointer
            if (ds_we) begin
              regs_nxt[ea[4:0]] = ds_wdata;
            end else begin
              ds_rdata_nxt = regs_r[ea[4:0]];
            end
            ds_done_nxt = 1'b1;
          end else if (ea <= IO_LAST) begin
            if (io_off == SP_LO_IO) begin
              if (ds_we) sp_nxt[7:0] = ds_wdata;
              else ds_rdata_nxt = sp_r[7:0];
              ds_done_nxt = 1'b1;
            end else if (io_off == SP_HI_IO) begin
              if (ds_we) sp_nxt[15:8] = ds_wdata;
              else ds_rdata_nxt = sp_r[15:8];
              ds_done_nxt = 1'b1;
            end else begin
              io_req_nxt = 1'b1;
              io_we_nxt = ds_we;
              io_idx_nxt = io_off;
              io_wdata_nxt = ds_wdata;
              ds_done_nxt = ds_we;
              state_nxt = ds_we ? ST_IDLE : ST_IO_WAIT;
            end
          end else if (in_sram(ea)) begin
            mem_addr = sram_idx(ea);
            mem_wdata = ds_wdata;
            mem_we = ds_we;
            mem_re = !ds_we;
            ds_done_nxt = ds_we;
            state_nxt = ds_we ? ST_IDLE : ST_MEM_WAIT;
          end else begin
            // nothing behind this address: writes drop, reads give zero
            ds_rdata_nxt = 8'h00;
            ds_done_nxt = 1'b1;
          end
        end
      end
      ST_IO_WAIT: begin
        ds_rdata_nxt = io_rdata;
        ds_done_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_MEM_WAIT: begin
        ds_rdata_nxt = mem_q;
        ds_done_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_PUSH_HI: begin
        mem_we = in_sram(sp_r);
        mem_addr = sram_idx(sp_r);
        mem_wdata = {{(16 - PC_W){1'b0}}, pc_hold_r[PC_W-1:8]};
        sp_nxt = sp_r - 16'h0001;
        ds_done_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_POP_A: begin
        pc_hold_nxt = {mem_q[PC_W-9:0], pc_hold_r[7:0]};
        mem_re = 1'b1;
        mem_addr = sram_idx(sp_r + 16'h0001);
        sp_nxt = sp_r + 16'h0001;
        state_nxt = ST_POP_B;
      end
      ST_POP_B: begin
        stk_pc_nxt = {pc_hold_r[PC_W-1:8], mem_q};
        ds_done_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    // result write lands last so it wins a same-cycle clash
    if (res_we) begin
      regs_nxt[eff_idx(res_idx, res_imm)] = res_data;
    end
    // operands see every write of this cycle
    operand_a_nxt = regs_nxt[eff_idx(rs_a_idx, rs_imm)];
    operand_b_nxt = regs_nxt[rs_b_idx];
    ds_busy_nxt = (state_nxt != ST_IDLE);
  end

  // register file and data-space state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_r[i] <= REG_RESET;
      end
      state_r <= ST_IDLE;
      sp_r <= SP_RESET;
      operand_a_r <= 8'h00;
      operand_b_r <= 8'h00;
      ds_rdata_r <= 8'h00;
      ds_done_r <= 1'b0;
      ds_busy_r <= 1'b0;
      io_req_r <= 1'b0;
      io_we_r <= 1'b0;
      io_idx_r <= 6'h00;
      io_wdata_r <= 8'h00;
      pc_hold_r <= PC_RESET;
      stk_pc_r <= PC_RESET;
    end else begin
      regs_r <= regs_nxt;
      state_r <= state_nxt;
      sp_r <= sp_nxt;
      operand_a_r <= operand_a_nxt;
      operand_b_r <= operand_b_nxt;
      ds_rdata_r <= ds_rdata_nxt;
      ds_done_r <= ds_done_nxt;
      ds_busy_r <= ds_busy_nxt;
      io_req_r <= io_req_nxt;
      io_we_r <= io_we_nxt;
      io_idx_r <= io_idx_nxt;
      io_wdata_r <= io_wdata_nxt;
      pc_hold_r <= pc_hold_nxt;
      stk_pc_r <= stk_pc_nxt;
    end
  end

  // ----------------------------------------
  // instruction fetch stage
  // ----------------------------------------
  // prefetch the next word while the current one executes; stall on data-space work
  always_comb begin
    pm_addr_nxt = pm_addr_r + 12'h001;
    instr_nxt = pm_data;
    instr_pc_nxt = pm_addr_r;
    instr_valid_nxt = 1'b1;
    if (rel_jump && instr_valid_r) begin
      // target wraps inside the 4k-word space; the prefetched word is dropped
      pm_addr_nxt = instr_pc_r + 12'h001 + rel_offset;
      instr_valid_nxt = 1'b0;
    end else if (ds_busy_nxt) begin
      pm_addr_nxt = pm_addr_r;
      instr_nxt = instr_r;
      instr_pc_nxt = instr_pc_r;
      instr_valid_nxt = 1'b0;
    end
  end

  // fetch stage registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pm_addr_r <= PC_RESET;
      instr_r <= 16'h0000;
      instr_pc_r <= PC_RESET;
      instr_valid_r <= 1'b0;
    end else begin
      pm_addr_r <= pm_addr_nxt;
      instr_r <= instr_nxt;
      instr_pc_r <= instr_pc_nxt;
      instr_valid_r <= instr_valid_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign operand_a = operand_a_r;
  assign operand_b = operand_b_r;
  assign ds_rdata = ds_rdata_r;
  assign ds_done = ds_done_r;
  assign ds_busy = ds_busy_r;
  assign io_req = io_req_r;
  assign io_we = io_we_r;
  assign io_idx = io_idx_r;
  assign io_wdata = io_wdata_r;
  assign stk_pc_out = stk_pc_r;
  assign stack_pointer = sp_r;
  assign pm_addr = pm_addr_r;
  assign instr = instr_r;
  assign instr_valid = instr_valid_r;

endmodule

// file: test/cpu_regfile_sva.sv
// port-level assertion checker for the cpu register file
`timescale 1ns/10ps
module cpu_regfile_sva (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [4:0] rs_a_idx,
  input wire logic [4:0] rs_b_idx,
  input wire logic rs_imm,
  input wire logic [7:0] operand_a,
  input wire logic [7:0] operand_b,
  input wire logic res_we,
  input wire logic [4:0] res_idx,
  input wire logic res_imm,
  input wire logic [7:0] res_data,
  input wire logic ds_req,
  input wire logic ds_we,
  input cpu_regfile_pkg::ds_mode_type ds_mode,
  input wire logic [15:0] ds_addr,
  input wire logic ds_done,
  input wire logic ds_busy,
  input wire logic io_req,
  input wire logic [5:0] io_idx,
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic [15:0] stack_pointer,
  input wire logic [11:0] pm_addr,
  input wire logic [15:0] pm_data,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic rel_jump,
  input wire logic [11:0] rel_offset
);
  import cpu_regfile_pkg::*;
  logic take;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // a data-space request the block accepts at this edge
  assign take = ds_req && !ds_busy && !stk_push && !stk_pop;
  // ---------------------------------------------
  // register port
  // ---------------------------------------------
  wr_through_a: assert property (
    res_we && !res_imm && !rs_imm && rs_a_idx == res_idx |=> operand_a == $past(res_data))
    else $error("operand a missed the result write");
  imm_upper_a: assert property (
    res_we && res_imm && !rs_imm && rs_b_idx == {1'b1, res_idx[3:0]}
    |=> operand_b == $past(res_data)) else $error("immediate write not in upper half");
  // ---------------------------------------------
  // data space and stack
  // ---------------------------------------------
  reg_map_a: assert property (
    take && ds_mode == MODE_DIRECT && ds_addr < 16'h0020 |=> ds_done && !ds_busy)
    else $error("register-range access not done in one cycle");
  io_read_a: assert property (
    take && !ds_we && ds_mode == MODE_DIRECT && ds_addr inside {[16'h0020:16'h005d]}
    |=> io_req && io_idx == 6'($past(ds_addr) - 16'h0020) ##1 ds_done && !io_req)
    else $error("io window read misrouted");
  push_stack_a: assert property (
    stk_push && !ds_busy |=> ds_busy ##1 ds_done && stack_pointer == $past(stack_pointer, 2)
    - 16'h0002) else $error("push did not lower the stack pointer by two");
  pop_stack_a: assert property (
    stk_pop && !stk_push && !ds_busy |=> ds_busy [*2] ##1 ds_done
    && stack_pointer == $past(stack_pointer, 3) + 16'h0002) else $error("pop stack pointer");
  // ---------------------------------------------
  // fetch
  // ---------------------------------------------
  rel_jump_a: assert property (
    rel_jump && instr_valid |=> !instr_valid && pm_addr == $past(pm_addr) + $past(rel_offset))
    else $error("relative jump target wrong");
  fetch_step_a: assert property (
    !ds_busy && !ds_req && !stk_push && !stk_pop && !rel_jump
    |=> instr_valid && instr == $past(pm_data) && pm_addr == $past(pm_addr) + 12'h001)
    else $error("fetch did not advance one word");
  cover property (take && ds_mode == MODE_POSTINC);
  cover property (stk_pop && !ds_busy);
  cover property (rel_jump && instr_valid);
endmodule

bind cpu_regfile cpu_regfile_sva checker_i (
  .clock(clock), .resetn(resetn), .rs_a_idx(rs_a_idx), .rs_b_idx(rs_b_idx),
  .rs_imm(rs_imm), .operand_a(operand_a), .operand_b(operand_b), .res_we(res_we),
  .res_idx(res_idx), .res_imm(res_imm), .res_data(res_data), .ds_req(ds_req),
  .ds_we(ds_we), .ds_mode(ds_mode), .ds_addr(ds_addr), .ds_done(ds_done),
  .ds_busy(ds_busy), .io_req(io_req), .io_idx(io_idx), .stk_push(stk_push),
  .stk_pop(stk_pop), .stack_pointer(stack_pointer), .pm_addr(pm_addr), .pm_data(pm_data),
  .instr(instr), .instr_valid(instr_valid), .rel_jump(rel_jump), .rel_offset(rel_offset)
);

// file: test/cpu_regfile_far.sv
// program memory and io space model on the far side of the register file
`timescale 1ns/10ps
module cpu_regfile_far (
  input wire logic clock,
  input wire logic [11:0] pm_addr,
  output logic [15:0] pm_data,
  input wire logic io_req,
  input wire logic io_we,
  input wire logic [5:0] io_idx,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata
);
  logic [7:0] io_mem [64];
  // io locations start from a known pattern
  initial begin
    for (int i = 0; i < 64; i++) begin
      io_mem[i] = 8'(i) ^ 8'h3c;
    end
  end
  // each word carries its own address so fetches are predictable
  assign pm_data = {4'hc, pm_addr};
  // data only while requested, inverted otherwise so stale values never pass
  assign io_rdata = io_req ? io_mem[io_idx] : ~io_mem[io_idx];
  always @(posedge clock) begin
    if (io_req && io_we) begin
      io_mem[io_idx] <= io_wdata;
    end
  end
endmodule

// file: test/cpu_regfile_bench.sv
// self-checking bench for the cpu register file
`timescale 1ns/10ps
module cpu_regfile_bench;
  import cpu_regfile_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic rs_imm = 1'b0, res_we = 1'b0, res_imm = 1'b0, ds_req = 1'b0, ds_we = 1'b0;
  logic stk_push = 1'b0, stk_pop = 1'b0, rel_jump = 1'b0;
  logic [4:0] rs_a_idx = 5'h00, rs_b_idx = 5'h00, res_idx = 5'h00;
  logic [7:0] res_data = 8'h00, ds_wdata = 8'h00;
  logic [5:0] ds_disp = 6'h00;
  logic [15:0] ds_addr = 16'h0000;
  logic [11:0] stk_pc_in = 12'h000, rel_offset = 12'h000, p;
  ds_mode_type ds_mode = MODE_DIRECT;
  ptr_sel_type ds_ptr_sel = PTR_X;
  logic [7:0] operand_a, operand_b, ds_rdata, io_wdata, io_rdata;
  logic [15:0] ptr_x, ptr_y, ptr_z, stack_pointer, instr, pm_data;
  logic [11:0] stk_pc_out, pm_addr;
  logic [5:0] io_idx;
  logic ds_done, ds_busy, io_req, io_we, instr_valid;
  int error_cnt = 0, comparisons = 0;

  always #2.5 clock = ~clock;

  cpu_regfile #(.SRAM_DEPTH(512)) DUT (
    .clock(clock), .resetn(resetn), .rs_a_idx(rs_a_idx), .rs_b_idx(rs_b_idx),
    .rs_imm(rs_imm), .operand_a(operand_a), .operand_b(operand_b), .res_we(res_we),
    .res_idx(res_idx), .res_imm(res_imm), .res_data(res_data), .ptr_x(ptr_x),
    .ptr_y(ptr_y), .ptr_z(ptr_z), .ds_req(ds_req), .ds_we(ds_we), .ds_mode(ds_mode),
    .ds_ptr_sel(ds_ptr_sel), .ds_disp(ds_disp), .ds_addr(ds_addr), .ds_wdata(ds_wdata),
    .ds_rdata(ds_rdata), .ds_done(ds_done), .ds_busy(ds_busy), .io_req(io_req),
    .io_we(io_we), .io_idx(io_idx), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .stk_push(stk_push), .stk_pop(stk_pop), .stk_pc_in(stk_pc_in), .stk_pc_out(stk_pc_out),
    .stack_pointer(stack_pointer), .pm_addr(pm_addr), .pm_data(pm_data), .instr(instr),
    .instr_valid(instr_valid), .rel_jump(rel_jump), .rel_offset(rel_offset)
  );
  cpu_regfile_far far (
    .clock(clock), .pm_addr(pm_addr), .pm_data(pm_data), .io_req(io_req), .io_we(io_we),
    .io_idx(io_idx), .io_wdata(io_wdata), .io_rdata(io_rdata)
  );
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task close_out;
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] val(input logic [4:0] i);
    val = {3'h0, i} * 8'h07 + 8'h03;
  endfunction
  // inputs always move 1 ns after the rising edge
  task tick;
    @(posedge clock);
    #1;
  endtask
  // waits bounded for completion, then leaves one edge before the next request
  task wait_done;
    int n;
    n = 0;
    while (ds_done !== 1'b1) begin
      tick();
      n++;
      if (n > 8) begin
        error_cnt++;
        $display("BAD %0t no completion", $time);
        close_out();
      end
    end
    tick();
  endtask
  // result write; the write-through operand is checked at the next edge
  task wr(input logic [4:0] i, input logic [7:0] d, input logic imm);
    res_we = 1'b1;
    res_idx = i;
    res_data = d;
    res_imm = imm;
    rs_a_idx = i;
    rs_b_idx = {1'b1, i[3:0]};
    tick();
    chk8(imm ? operand_b : operand_a, d);
  endtask
  task ds(input logic w, input ds_mode_type m, input ptr_sel_type s, input logic [5:0] d,
      input logic [15:0] a, input logic [7:0] wd);
    ds_we = w;
    ds_mode = m;
    ds_ptr_sel = s;
    ds_disp = d;
    ds_addr = a;
    ds_wdata = wd;
    ds_req = 1'b1;
    tick();
    ds_req = 1'b0;
    wait_done();
  endtask
  task dr(input logic [15:0] a, input logic [7:0] exp);
    ds(1'b0, MODE_DIRECT, PTR_X, 6'h00, a, 8'h00);
    chk8(ds_rdata, exp);
  endtask
  task stk(input logic push, input logic [11:0] pc);
    stk_push = push;
    stk_pop = !push;
    stk_pc_in = pc;
    tick();
    stk_push = 1'b0;
    stk_pop = 1'b0;
    wait_done();
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task t_reset;
    chk16(ptr_x, 16'h0000);
    chk16(stack_pointer, 16'h0000);
    chk8(operand_a, 8'h00);
  endtask
  task t_regs;
    for (int i = 0; i < 32; i++) wr(5'(i), val(5'(i)), 1'b0);
    res_we = 1'b0;
    for (int i = 0; i < 32; i++) begin
      rs_a_idx = 5'(i);
      rs_b_idx = 5'(31 - i);
      tick();
      chk8(operand_a, val(5'(i)));
      chk8(operand_b, val(5'(31 - i)));
    end
    chk16(ptr_x, {val(5'd27), val(5'd26)});
    chk16(ptr_y, {val(5'd29), val(5'd28)});
    chk16(ptr_z, {val(5'd31), val(5'd30)});
    wr(5'h03, 8'h5c, 1'b1);
    res_we = 1'b0;
    res_imm = 1'b0;
    rs_a_idx = 5'h03;
    rs_imm = 1'b1;
    tick();
    chk8(operand_a, 8'h5c);
    rs_imm = 1'b0;
    tick();
    chk8(operand_a, val(5'h03));
  endtask
  task t_map;
    dr(16'h0007, val(5'h07));
    ds(1'b1, MODE_DIRECT, PTR_X, 6'h00, 16'h0009, 8'h99);
    rs_a_idx = 5'h09;
    tick();
    chk8(operand_a, 8'h99);
    wr(5'h1a, 8'h0c, 1'b0);
    wr(5'h1b, 8'h00, 1'b0);
    res_we = 1'b0;
    ds(1'b0, MODE_INDIRECT, PTR_X, 6'h00, 16'h0000, 8'h00);
    chk8(ds_rdata, val(5'h0c));
    dr(16'h0260, 8'h00);
  endtask
  task t_io;
    dr(16'h0025, 8'h39);
    ds(1'b1, MODE_IO, PTR_X, 6'h06, 16'h0000, 8'h77);
    dr(16'h0026, 8'h77);
    ds(1'b1, MODE_DIRECT, PTR_X, 6'h00, 16'h005e, 8'h00);
    ds(1'b1, MODE_DIRECT, PTR_X, 6'h00, 16'h005f, 8'h01);
    chk16(stack_pointer, 16'h0100);
    dr(16'h005f, 8'h01);
  endtask
  task t_sram;
    wr(5'h1c, 8'h80, 1'b0);
    wr(5'h1d, 8'h00, 1'b0);
    wr(5'h1e, 8'h90, 1'b0);
    wr(5'h1f, 8'h00, 1'b0);
    res_we = 1'b0;
    ds(1'b1, MODE_POSTINC, PTR_Y, 6'h00, 16'h0000, 8'ha1);
    chk16(ptr_y, 16'h0081);
    ds(1'b1, MODE_PREDEC, PTR_Z, 6'h00, 16'h0000, 8'hb2);
    chk16(ptr_z, 16'h008f);
    ds(1'b1, MODE_DIRECT, PTR_X, 6'h00, 16'h0086, 8'hc3);
    ds(1'b0, MODE_DISP, PTR_Y, 6'h05, 16'h0000, 8'h00);
    chk8(ds_rdata, 8'hc3);
    ds(1'b0, MODE_INDIRECT, PTR_Z, 6'h00, 16'h0000, 8'h00);
    chk8(ds_rdata, 8'hb2);
    dr(16'h0080, 8'ha1);
    ds(1'b1, MODE_DISP, PTR_Z, 6'h3f, 16'h0000, 8'hd4);
    dr(16'h00ce, 8'hd4);
  endtask
  task t_stack;
    stk(1'b1, 12'h123);
    chk16(stack_pointer, 16'h00fe);
    dr(16'h0100, 8'h23);
    dr(16'h00ff, 8'h01);
    stk(1'b0, 12'h000);
    chk16({4'h0, stk_pc_out}, 16'h0123);
    chk16(stack_pointer, 16'h0100);
  endtask
  task t_fetch;
    p = pm_addr;
    tick();
    chk16(instr, {4'hc, p});
    chk16({4'h0, pm_addr}, {4'h0, p + 12'h001});
    chk8({7'h00, instr_valid}, 8'h01);
    rel_offset = 12'h003 - pm_addr;
    rel_jump = 1'b1;
    tick();
    rel_jump = 1'b0;
    chk16({4'h0, pm_addr}, 16'h0003);
    chk8({7'h00, instr_valid}, 8'h00);
    tick();
    chk16(instr, 16'hc003);
  endtask
  // reset again in mid-run: state clears, fetch restarts from word 0
  task t_rerun;
    resetn = 1'b0;
    tick();
    chk16(ptr_z, 16'h0000);
    chk16(stack_pointer, 16'h0000);
    chk8(operand_b, 8'h00);
    resetn = 1'b1;
    tick();
    chk16(instr, 16'hc000);
    chk8({7'h00, instr_valid}, 8'h01);
  endtask
  // reset for three cycles, then run every scenario
  initial begin
    repeat (3) @(posedge clock);
    #1;
    resetn = 1'b1;
    t_reset();
    t_regs();
    t_map();
    t_io();
    t_sram();
    t_stack();
    t_fetch();
    t_rerun();
    close_out();
  end
endmodule
